// File: tb_top.sv
// self-checking testbench of the window watchdog
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   localparam int TK   = 2;
   localparam int HOLD = 50;
   localparam int LEAD = int'(wdf_pkg::LEAD_TICKS) * TK;
   localparam int CLO  = int'(wdf_pkg::CLOSED_TICKS) * TK;
   localparam int OPN  = int'(wdf_pkg::OPEN_TICKS) * TK;

   logic                   clock;
   logic                   sys_rst;
   logic                   trig_n;
   logic                   en;
   logic                   txd;
   logic                   enable_float;
   logic                   txd_float;
   logic                   bus_dominant;
   logic                   local_wake;
   wdf_pkg::wdf_fault_type faults;
   logic [15:0]            osc_set;
   logic                   reset_out_n;
   logic                   rx_data;
   logic                   bus_drive_dominant;
   logic                   regulator_on;
   wdf_pkg::wdf_mode_type  mode;
   int                     err_count;
   int                     n_compared;

   wdf_host_model i_host (.clock(clock), .watchdog_trigger_n(trig_n), .enable_pin(en),
      .txd_pin(txd));

   wdf_watchdog #(.RESET_HOLD_CYC(HOLD)) i_dut (.clock(clock), .sys_rst(sys_rst),
      .watchdog_trigger_n(trig_n), .enable_pin(en), .enable_float(enable_float),
      .txd_pin(txd), .txd_float(txd_float), .bus_dominant(bus_dominant),
      .local_wake(local_wake), .oscillator_resistor_pin(osc_set), .faults(faults),
      .reset_out_n(reset_out_n), .rx_data(rx_data), .bus_drive_dominant(bus_drive_dominant),
      .regulator_on(regulator_on), .mode(mode));

   initial begin
      clock = 1'b0;
      sys_rst = 1'b1;
      {enable_float, txd_float, bus_dominant, local_wake} = 4'h0;
      faults = '0;
      osc_set = 16'(TK);
      err_count = 0;
      n_compared = 0;
   end

   always #5 clock = ~clock;

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [2:0] exp, input logic [2:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic wait_lvl(input logic v, input int lim, output int n);
      n = 0;
      while (reset_out_n !== v && n < lim) begin
         @(negedge clock);
         n++;
      end
   endtask

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic do_reset(input logic en_lvl);
      i_host.pins(en_lvl, 1'b1);
      sys_rst = 1'b1;
      cyc(3);
      check("rx_data", 1, rx_data);
      sys_rst = 1'b0;
      check("reset_out_n", 0, reset_out_n);
      cyc(HOLD - 5);
      check("reset_out_n", 0, reset_out_n);
      cyc(12);
      check("reset_out_n", 1, reset_out_n);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_lead_timeout;
      int n;
      // one clock per oscillator period: lead time shrinks, reset width must not
      osc_set = 16'h0001;
      do_reset(1'b1);
      check("mode", wdf_pkg::MODE_NORMAL, mode);
      cyc(LEAD / TK - 100);
      check("reset_out_n", 1, reset_out_n);
      wait_lvl(1'b0, 200, n);
      check("lead_end", 1, n >= 80 && n <= 120);
      cyc(3);
      check("mode", wdf_pkg::MODE_FAILSAFE, mode);
      wait_lvl(1'b1, HOLD + 20, n);
      check("reset_width", 1, n + 3 >= HOLD && n + 3 <= HOLD + 5);
      cyc(8);
      check("mode", wdf_pkg::MODE_NORMAL, mode);
      osc_set = 16'(TK);
   endtask

   task automatic t_windows;
      int n;
      do_reset(1'b1);
      i_host.pulse(30);
      cyc(CLO + 60);
      i_host.pulse(30);
      cyc(20);
      check("reset_out_n", 1, reset_out_n);
      cyc(180);
      i_host.pulse(15);
      cyc(40);
      check("reset_out_n", 1, reset_out_n);
      cyc(CLO + OPN - 362);
      check("reset_out_n", 1, reset_out_n);
      wait_lvl(1'b0, 200, n);
      check("open_end", 1, n >= 80 && n <= 120);
      wait_lvl(1'b1, HOLD + 20, n);
      cyc(100);
      i_host.pulse(30);
      cyc(100);
      i_host.pulse(30);
      cyc(2);
      check("reset_out_n", 0, reset_out_n);
   endtask

   task automatic t_silent;
      int n;
      do_reset(1'b1);
      bus_dominant = 1'b1;
      cyc(6);
      check("rx_data", 0, rx_data);
      i_host.pins(1'b0, 1'b1);
      cyc(6);
      check("mode", wdf_pkg::MODE_SILENT, mode);
      cyc(LEAD + 200);
      check("reset_out_n", 1, reset_out_n);
      bus_dominant = 1'b0;
      cyc(6);
      check("mode", wdf_pkg::MODE_FAILSAFE, mode);
      check("rx_data", 0, rx_data);
      cyc(LEAD - 100);
      wait_lvl(1'b0, 200, n);
      check("wake_lead_end", 1, n >= 80 && n <= 120);
   endtask

   task automatic t_sleep;
      do_reset(1'b1);
      i_host.pins(1'b0, 1'b0);
      cyc(6);
      check("mode", wdf_pkg::MODE_SLEEP, mode);
      local_wake = 1'b1;
      cyc(6);
      check("mode", wdf_pkg::MODE_FAILSAFE, mode);
      check("rx_data", 0, rx_data);
      local_wake = 1'b0;
   endtask

   task automatic t_faults;
      do_reset(1'b1);
      i_host.pins(1'b1, 1'b0);
      cyc(6);
      check("bus_drive", 1, bus_drive_dominant);
      txd_float = 1'b1;
      cyc(6);
      check("bus_drive", 0, bus_drive_dominant);
      txd_float = 1'b0;
      faults.bus_overtemp = 1'b1;
      cyc(6);
      check("bus_drive", 0, bus_drive_dominant);
      check("regulator_on", 1, regulator_on);
      faults.bus_overtemp = 1'b0;
      cyc(6);
      check("bus_drive", 1, bus_drive_dominant);
      faults.vcc_undervoltage = 1'b1;
      cyc(6);
      check("reset_out_n", 0, reset_out_n);
      check("mode", wdf_pkg::MODE_FAILSAFE, mode);
      i_host.pins(1'b0, 1'b1);
      faults.vcc_overtemp = 1'b1;
      cyc(6);
      check("regulator_on", 0, regulator_on);
      faults = '0;
      cyc(8);
      check("regulator_on", 1, regulator_on);
      enable_float = 1'b1;
      i_host.pins(1'b1, 1'b1);
      cyc(HOLD + 20);
      check("mode", wdf_pkg::MODE_FAILSAFE, mode);
      enable_float = 1'b0;
      cyc(8);
      check("mode", wdf_pkg::MODE_NORMAL, mode);
   endtask

   task automatic t_fallback;
      for (int i = 0; i < 2; i++) begin
         faults.osc_open = (i == 0);
         faults.osc_short = (i == 1);
         do_reset(1'b1);
         i_host.pulse(30);
         cyc(3000);
         i_host.pulse(30);
         cyc(2);
         check("reset_out_n", 0, reset_out_n);
      end
      faults = '0;
   endtask

   initial begin
      repeat (80000) @(posedge clock);
      err_count++;
      $display("unexpected watchdog expiry expected done seen hang");
      conclude();
   end

   initial begin
      cyc(1);
      t_lead_timeout();
      t_windows();
      t_silent();
      t_sleep();
      t_faults();
      t_fallback();
      conclude();
   end
endmodule

`default_nettype wire

// File: wdf_host_model.sv
// host controller model driving trigger and mode pins
`timescale 1ns/100ps
`default_nettype none

module wdf_host_model (
   // clock
   input  wire logic clock,
   // host pins
   output logic      watchdog_trigger_n,
   output logic      enable_pin,
   output logic      txd_pin
);
   initial begin
      watchdog_trigger_n = 1'b1;
      enable_pin = 1'b0;
      txd_pin = 1'b1;
   end

   task automatic pulse(input int low_cyc);
      @(negedge clock);
      watchdog_trigger_n = 1'b0;
      repeat (low_cyc) @(negedge clock);
      watchdog_trigger_n = 1'b1;
   endtask

   task automatic pins(input logic en, input logic txd);
      @(negedge clock);
      enable_pin = en;
      txd_pin = txd;
   endtask
endmodule

`default_nettype wire

// File: wdf_pkg.sv
// shared constants and types of the window watchdog and fail-safe logic
package wdf_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 10;
   localparam int TRIG_MIN_NS       = 200;
   localparam int TRIG_MIN_CYC      = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int RESET_TIME_MS     = 4;
   localparam int RESET_HOLD_CYC    = (RESET_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int FALLBACK_OSC_NS   = 100000;
   localparam int FALLBACK_OSC_CYC  = FALLBACK_OSC_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // watchdog intervals in oscillator periods
   // ----------------------------------------------------------------
   localparam logic [12:0] LEAD_TICKS   = 13'd7895;
   localparam logic [12:0] CLOSED_TICKS = 13'd1053;
   localparam logic [12:0] OPEN_TICKS   = 13'd1105;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int OSC_W = 16;
   localparam int RST_W = 20;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_FAILSAFE,
      MODE_NORMAL,
      MODE_SILENT,
      MODE_SLEEP
   } wdf_mode_type;

   typedef enum logic [2:0] {
      WD_HOLD,
      WD_OFF,
      WD_LEAD,
      WD_CLOSED,
      WD_OPEN
   } wdf_wd_type;

   // fault sense levels from the analog side
   typedef struct packed {
      logic bus_overtemp;
      logic vcc_overtemp;
      logic vcc_undervoltage;
      logic osc_short;
      logic osc_open;
   } wdf_fault_type;

endpackage

// File: wdf_trigger_filter.sv
// trigger pin synchroniser and minimum-low-width glitch filter
`timescale 1ns/100ps
`default_nettype none

module wdf_trigger_filter (
   // clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   // trigger pin
   input  wire logic watchdog_trigger_n,
   // qualified trigger
   output logic      trig_valid
);

   localparam logic [7:0] MIN_LOW = 8'(wdf_pkg::TRIG_MIN_CYC);

   logic       sync1_r;
   logic       sync2_r;
   logic [7:0] low_cnt_r;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
      end else begin
         sync1_r <= watchdog_trigger_n;
         sync2_r <= sync1_r;
      end
   end

   // low pulses shorter than the minimum are dropped
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         low_cnt_r <= 8'h00;
      end else if (sync2_r) begin
         low_cnt_r <= 8'h00;
      end else if (low_cnt_r != MIN_LOW) begin
         low_cnt_r <= low_cnt_r + 8'h01;
      end
   end

   // one pulse per low phase, once it is long enough
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         trig_valid <= 1'b0;
      end else begin
         trig_valid <= !sync2_r && (low_cnt_r == MIN_LOW - 8'h01);
      end
   end

endmodule

`default_nettype wire

// File: wdf_watchdog.sv
// window watchdog, reset generator and fail-safe mode control
`timescale 1ns/100ps
`default_nettype none

module wdf_watchdog #(
   parameter int RESET_HOLD_CYC = wdf_pkg::RESET_HOLD_CYC
) (
   // clock and reset
   input  wire logic                        clock,
   input  wire logic                        sys_rst,
   // host pins
   input  wire logic                        watchdog_trigger_n,
   input  wire logic                        enable_pin,
   input  wire logic                        enable_float,
   input  wire logic                        txd_pin,
   input  wire logic                        txd_float,
   // bus and wake sense
   input  wire logic                        bus_dominant,
   input  wire logic                        local_wake,
   // oscillator setting and fault sense
   input  wire logic [wdf_pkg::OSC_W-1:0]   oscillator_resistor_pin,
   input  wire wdf_pkg::wdf_fault_type      faults,
   // outputs
   output logic                             reset_out_n,
   output logic                             rx_data,
   output logic                             bus_drive_dominant,
   output logic                             regulator_on,
   output wdf_pkg::wdf_mode_type            mode
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam int SW = 11;

   logic [SW-1:0] pin_s1_r;
   logic [SW-1:0] pin_s2_r;
   logic          en_eff;
   logic          txd_eff;
   logic          bus_dom_s;
   logic          lwake_s;
   wdf_pkg::wdf_fault_type flt_s;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pin_s1_r <= {enable_pin, enable_float, txd_pin, txd_float,
                      bus_dominant, local_wake, faults};
         pin_s2_r <= pin_s1_r;
      end
   end

   // floating pins read as their safe levels
   assign en_eff    = pin_s2_r[10] && !pin_s2_r[9];
   assign txd_eff   = pin_s2_r[8] || pin_s2_r[7];
   assign bus_dom_s = pin_s2_r[6];
   assign lwake_s   = pin_s2_r[5];
   assign flt_s     = pin_s2_r[4:0];

   // ----------------------------------------------------------------
   // edge history
   // ----------------------------------------------------------------
   logic en_d_r;
   logic bus_d_r;
   logic lwake_d_r;
   logic en_fall;
   logic bus_release;
   logic lwake_rise;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         en_d_r    <= 1'b0;
         bus_d_r   <= 1'b0;
         lwake_d_r <= 1'b0;
      end else begin
         en_d_r    <= en_eff;
         bus_d_r   <= bus_dom_s;
         lwake_d_r <= lwake_s;
      end
   end

   assign en_fall     = en_d_r && !en_eff;
   assign bus_release = bus_d_r && !bus_dom_s;
   assign lwake_rise  = !lwake_d_r && lwake_s;

   // ----------------------------------------------------------------
   // trigger qualification
   // ----------------------------------------------------------------
   logic trig;

   wdf_trigger_filter u_trig (
      .clock              (clock),
      .sys_rst            (sys_rst),
      .watchdog_trigger_n (watchdog_trigger_n),
      .trig_valid         (trig)
   );

   // ----------------------------------------------------------------
   // watchdog oscillator
   // ----------------------------------------------------------------
   logic [wdf_pkg::OSC_W-1:0] osc_per;
   logic [wdf_pkg::OSC_W-1:0] osc_cnt_r;
   logic                      osc_tick;

   // resistor fault selects the internal fallback period
   assign osc_per = (flt_s.osc_short || flt_s.osc_open)
                    ? wdf_pkg::OSC_W'(wdf_pkg::FALLBACK_OSC_CYC)
                    : oscillator_resistor_pin;
   assign osc_tick = (osc_cnt_r == '0);

   // free-running prescaler gives one tick per oscillator period
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         osc_cnt_r <= '0;
      end else if (osc_tick || osc_cnt_r >= osc_per) begin
         osc_cnt_r <= (osc_per == '0) ? '0 : osc_per - 1'b1;
      end else begin
         osc_cnt_r <= osc_cnt_r - 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // mode control
   // ----------------------------------------------------------------
   logic rst_active_r;
   logic low_power;
   logic wake;

   assign low_power = (mode == wdf_pkg::MODE_SILENT) || (mode == wdf_pkg::MODE_SLEEP);
   // end of a bus short counts as a remote wake
   assign wake = low_power && (bus_release || lwake_rise);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mode <= wdf_pkg::MODE_FAILSAFE;
      end else if (rst_active_r && mode != wdf_pkg::MODE_SLEEP) begin
         mode <= wdf_pkg::MODE_FAILSAFE;
      end else begin
         unique case (mode)
            wdf_pkg::MODE_FAILSAFE: begin
               if (en_eff) begin
                  mode <= wdf_pkg::MODE_NORMAL;
               end
            end
            wdf_pkg::MODE_NORMAL: begin
               // entry regardless of bus or stuck transmit
               if (en_fall) begin
                  mode <= txd_eff ? wdf_pkg::MODE_SILENT : wdf_pkg::MODE_SLEEP;
               end
            end
            wdf_pkg::MODE_SILENT,
            wdf_pkg::MODE_SLEEP: begin
               if (wake) begin
                  mode <= wdf_pkg::MODE_FAILSAFE;
               end
            end
         endcase
      end
   end

   // wake request flag shown low on receive; set wins over clear
   logic wake_flag_r;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wake_flag_r <= 1'b0;
      end else if (wake) begin
         wake_flag_r <= 1'b1;
      end else if (mode == wdf_pkg::MODE_NORMAL) begin
         wake_flag_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // reset pulse generator
   // ----------------------------------------------------------------
   localparam logic [wdf_pkg::RST_W-1:0] HOLD_LOAD = wdf_pkg::RST_W'(RESET_HOLD_CYC - 1);

   logic                      wd_fault;
   logic [wdf_pkg::RST_W-1:0] rst_cnt_r;

   // undervoltage holds and restarts the reset time
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rst_active_r <= 1'b1;
         rst_cnt_r    <= HOLD_LOAD;
      end else if (flt_s.vcc_undervoltage || wd_fault) begin
         rst_active_r <= 1'b1;
         rst_cnt_r    <= HOLD_LOAD;
      end else if (rst_cnt_r != '0) begin
         rst_cnt_r <= rst_cnt_r - 1'b1;
      end else begin
         rst_active_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // window watchdog
   // ----------------------------------------------------------------
   wdf_pkg::wdf_wd_type wd_state_r;
   logic [12:0]         wd_cnt_r;
   logic                wd_last;

   assign wd_last = osc_tick && (wd_cnt_r == 13'h0001);

   always_comb begin
      wd_fault = 1'b0;
      unique case (wd_state_r)
         wdf_pkg::WD_LEAD:   wd_fault = wd_last && !trig;
         wdf_pkg::WD_CLOSED: wd_fault = trig;
         wdf_pkg::WD_OPEN:   wd_fault = wd_last && !trig;
         default:            wd_fault = 1'b0;
      endcase
      // no watchdog reset while in low power
      if (low_power) begin
         wd_fault = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wd_state_r <= wdf_pkg::WD_HOLD;
         wd_cnt_r   <= 13'h0000;
      end else if (low_power) begin
         if (wake) begin
            // lead time from receive falling edge
            wd_state_r <= wdf_pkg::WD_LEAD;
            wd_cnt_r   <= wdf_pkg::LEAD_TICKS;
         end else begin
            wd_state_r <= wdf_pkg::WD_OFF;
         end
      end else if (rst_active_r || wd_fault) begin
         wd_state_r <= wdf_pkg::WD_HOLD;
      end else begin
         unique case (wd_state_r)
            wdf_pkg::WD_HOLD: begin
               wd_state_r <= wdf_pkg::WD_LEAD;
               wd_cnt_r   <= wdf_pkg::LEAD_TICKS;
            end
            wdf_pkg::WD_OFF: begin
               wd_state_r <= wdf_pkg::WD_LEAD;
               wd_cnt_r   <= wdf_pkg::LEAD_TICKS;
            end
            wdf_pkg::WD_LEAD: begin
               if (trig) begin
                  wd_state_r <= wdf_pkg::WD_CLOSED;
                  wd_cnt_r   <= wdf_pkg::CLOSED_TICKS;
               end else if (osc_tick) begin
                  // count lead time in oscillator periods
                  wd_cnt_r <= wd_cnt_r - 13'h0001;
               end
            end
            wdf_pkg::WD_CLOSED: begin
               if (wd_last) begin
                  wd_state_r <= wdf_pkg::WD_OPEN;
                  wd_cnt_r   <= wdf_pkg::OPEN_TICKS;
               end else if (osc_tick) begin
                  wd_cnt_r <= wd_cnt_r - 13'h0001;
               end
            end
            wdf_pkg::WD_OPEN: begin
               if (trig) begin
                  // restart with a new closed window
                  wd_state_r <= wdf_pkg::WD_CLOSED;
                  wd_cnt_r   <= wdf_pkg::CLOSED_TICKS;
               end else if (osc_tick) begin
                  wd_cnt_r <= wd_cnt_r - 13'h0001;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // reset output shared by undervoltage and watchdog
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reset_out_n <= 1'b0;
      end else begin
         reset_out_n <= !rst_active_r && !flt_s.vcc_undervoltage && !wd_fault;
      end
   end

   // driver only in normal mode and below overtemperature
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         bus_drive_dominant <= 1'b0;
      end else begin
         bus_drive_dominant <= (mode == wdf_pkg::MODE_NORMAL) && !flt_s.bus_overtemp
                               && !txd_eff;
      end
   end

   // receive follows the bus in normal mode, high while the bus is recessive; in other modes it shows the wake flag
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rx_data <= 1'b1;
      end else if (mode == wdf_pkg::MODE_NORMAL) begin
         rx_data <= !bus_dom_s;
      end else begin
         rx_data <= !wake_flag_r;
      end
   end

   // regulator back on after cooling, independent of enable
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         regulator_on <= 1'b0;
      end else begin
         regulator_on <= (mode != wdf_pkg::MODE_SLEEP) && !flt_s.vcc_overtemp;
      end
   end

endmodule

`default_nettype wire

// File: wdf_watchdog_props.sv
// assertion checker for the window watchdog top ports
`timescale 1ns/100ps
`default_nettype none

module wdf_watchdog_props #(
   parameter int RESET_HOLD_CYC = wdf_pkg::RESET_HOLD_CYC
) (
   // clock and reset
   input wire logic                   clock,
   input wire logic                   sys_rst,
   // pins and sense
   input wire logic                   enable_pin,
   input wire logic                   enable_float,
   input wire logic                   txd_float,
   input wire logic                   bus_dominant,
   input wire wdf_pkg::wdf_fault_type faults,
   // outputs
   input wire logic                   reset_out_n,
   input wire logic                   rx_data,
   input wire logic                   bus_drive_dominant,
   input wire logic                   regulator_on,
   input wire wdf_pkg::wdf_mode_type  mode
);
   int low_cnt_r;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   // ----------------------------------------------------------------
   // low time of the reset output
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         low_cnt_r <= 0;
      else if (reset_out_n)
         low_cnt_r <= 0;
      else
         low_cnt_r <= low_cnt_r + 1;
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   reset_width_a : assert property ($rose(reset_out_n) |-> low_cnt_r >= RESET_HOLD_CYC - 1)
      else $error("reset output released early");
   reset_failsafe_a : assert property ($fell(reset_out_n) && mode != wdf_pkg::MODE_SLEEP
      |-> ##[1:3] mode == wdf_pkg::MODE_FAILSAFE)
      else $error("reset low without fail-safe mode");
   silent_quiet_a : assert property (mode == wdf_pkg::MODE_SILENT && reset_out_n |=> reset_out_n)
      else $error("reset raised in silent mode");
   normal_entry_a : assert property ((mode == wdf_pkg::MODE_FAILSAFE && enable_pin
      && !enable_float && reset_out_n) [*3] |=> mode == wdf_pkg::MODE_NORMAL)
      else $error("enable high did not reach normal mode");
   bus_off_a : assert property (mode != wdf_pkg::MODE_NORMAL
      && $past(mode) != wdf_pkg::MODE_NORMAL |-> !bus_drive_dominant)
      else $error("bus driven outside normal mode");
   overtemp_off_a : assert property (faults.bus_overtemp [*4] |-> !bus_drive_dominant)
      else $error("bus driven during overtemperature");
   txd_float_a : assert property (txd_float [*4] |-> !bus_drive_dominant)
      else $error("floating transmit drove the bus");
   en_float_a : assert property ((enable_float && mode == wdf_pkg::MODE_FAILSAFE) [*5]
      |=> mode == wdf_pkg::MODE_FAILSAFE)
      else $error("floating enable left fail-safe mode");
   undervolt_reset_a : assert property (faults.vcc_undervoltage [*4] |-> !reset_out_n)
      else $error("undervoltage without reset");
   regulator_on_a : assert property ((mode == wdf_pkg::MODE_FAILSAFE
      && !faults.vcc_overtemp) [*6] |-> regulator_on)
      else $error("regulator off in fail-safe mode");
   rx_follow_a : assert property ((mode == wdf_pkg::MODE_NORMAL && bus_dominant) [*4]
      |-> !rx_data)
      else $error("receive output ignores dominant bus");

   cover property (mode == wdf_pkg::MODE_SILENT);
   cover property (mode == wdf_pkg::MODE_SLEEP);
   cover property ($fell(reset_out_n) && mode == wdf_pkg::MODE_NORMAL);
   cover property ($rose(reset_out_n));
endmodule

bind wdf_watchdog wdf_watchdog_props #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) i_props (
   .clock, .sys_rst, .enable_pin, .enable_float, .txd_float, .bus_dominant, .faults,
   .reset_out_n, .rx_data, .bus_drive_dominant, .regulator_on, .mode
);

`default_nettype wire
